/* bci_pkg.sv */
// shared constants and carriers for the bias controller two-wire slave
package bci_pkg;
  // fixed upper slave address nibble and high-speed master code prefix
  localparam logic [3:0] ADDR_HI = 4'h4;
  localparam logic [4:0] HS_CODE = 5'h01;
  // command byte layout: bit 7 set marks a read
  localparam int CMD_RD_BIT = 7;
  localparam logic [7:0] CMD_RD_QUEUE = 8'h80;
  localparam logic [7:0] CMD_RD_FLAG = 8'h82;
  localparam logic [7:0] CMD_RD_FINE1 = 8'hD2;
  localparam logic [7:0] CMD_RD_FINE2 = 8'hD6;
  localparam logic [7:0] CMD_WR_FINE1 = 8'h52;
  localparam logic [7:0] CMD_WR_FINE2 = 8'h56;
  localparam logic [7:0] CMD_WR_SCLR = 8'h6E;
  // software clear fields, positions within the 16-bit data word
  localparam int SCLR_FULL_BIT = 9;
  localparam int SCLR_ARM_BIT = 8;
  localparam int SCLR_CLQ_BIT = 6;
  // queue word tags
  localparam logic [3:0] TAG_CORRUPT = 4'hE;
  localparam logic [3:0] TAG_EMPTY = 4'hF;
  localparam logic [2:0] SRC_LAST = 3'h6;
  // status word fields and reset values
  localparam int ST_CONV = 11;
  localparam int ST_ARITH = 10;
  localparam int ST_EMPTY = 9;
  localparam int ST_OVF = 8;
  localparam logic ARITH_RST = 1'b1;
  localparam logic [7:0] ALARM_RST = 8'h00;
  localparam int FINE_W = 10;
  localparam logic [9:0] FINE_RST = 10'h000;

  // conversion sources in tag order
  typedef enum logic [2:0] {
    SRC_DIE, SRC_CH1_TEMP, SRC_CH1_CURR, SRC_AUX1,
    SRC_CH2_TEMP, SRC_CH2_CURR, SRC_AUX2
  } bci_src_e;

  typedef struct packed {
    logic [2:0] src;
    logic [11:0] value;
  } bci_qin_s;

  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] data;
  } bci_wr_s;
endpackage

/* bci_sync.sv */
// two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/10ps
module bci_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // reset to ones: idle bus lines rest high
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule // bci_sync

/* bci_slave.sv */
// two-wire slave register access for the bias controller
`timescale 1ns/10ps
//
// Contract
// - queue word: 4-bit tag over 12-bit value
// - tags 0..6 name the conversion source
// - overflow during readout gives tag 1110
// - empty queue gives tag 1111 plus status
// - addressed read: write address, command, Sr, read
// - word sent high byte then low
// - master ACK keeps words coming
// - short read returns last accessed register
// - address is 0100 plus three pins
// - eighth address bit selects direction
// - command byte gives register and direction
// - bytes move MSB first
// - status busy, arith, empty, overflow at 11..8
// - status 7..0 are alarms, reset zero
// - SDA change while SCL high is control
// - detect START and STOP
// - repeated START keeps speed mode
// - idle bus: both lines released
// - ACK holds SDA low for ninth pulse
// - no ACK after full clear write
// - fast mode after reset
// - commands chain within one transaction
// - write: address, command, high, low bytes
// - status read clears overflow and alarms
// - code 00001XXX: NACK, high speed, STOP ends
module bci_slave
  import bci_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_addr_pin_bit0,
  input wire logic i_addr_pin_bit1,
  input wire logic i_addr_pin_bit2,
  input wire logic i_q_valid,
  input wire bci_qin_s i_q_word,
  input wire logic i_q_overflow,
  input wire logic i_converter_active,
  input wire logic i_arith_unit_active,
  input wire logic [7:0] i_alarm_set,
  output logic o_sda_o,
  output logic o_sda_oe_n,
  output logic o_q_pop,
  output logic o_q_clear,
  output logic o_complete_dac_clear,
  output logic o_wr_stb,
  output bci_wr_s o_wr,
  output logic o_hs_mode
);
  typedef enum {S_IDLE, S_RX, S_RXACK, S_TX, S_TXACK, S_SKIP} bci_state_e;
  typedef enum {K_ADDR, K_CMD, K_DHI, K_DLO} bci_kind_e;
  // source to tag; an out-of-range source is flagged corrupt
  function automatic logic [3:0] src_tag(input logic [2:0] s);
    src_tag = (s > SRC_LAST) ? TAG_CORRUPT : {1'b0, s};
  endfunction
  function automatic logic cmd_is_read(input logic [7:0] c);
    cmd_is_read = c[CMD_RD_BIT];
  endfunction
  logic scl_s, sda_s, scl_p, sda_p;
  logic [2:0] pins_s;
  bci_state_e state_q;
  bci_kind_e kind_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, cmd_q, last_q, dhi_q;
  logic [15:0] txw_q;
  logic ack_q, rd_q, mack_q, tx_lo_q, bus_q, first_q, hs_q, hs_pend_q;
  logic armed_q, ovf_q, arith_q, clq_q, full_q, wr_stb_q;
  logic [7:0] alarm_q;
  logic [FINE_W-1:0] fine1_q, fine2_q;
  bci_wr_s wr_q;
  // pins pass two flops; scl is only sampled, its edges found here
  bci_sync #(.W(5)) u_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_async({i_scl, i_sda, i_addr_pin_bit2, i_addr_pin_bit1,
              i_addr_pin_bit0}),
    .o_sync({scl_s, sda_s, pins_s})
  );
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
    end
  end
  // bus events from the synchronised lines
  wire scl_rise = scl_s & ~scl_p;
  wire scl_fall = ~scl_s & scl_p;
  wire start_c = scl_s & scl_p & sda_p & ~sda_s;
  wire stop_c = scl_s & scl_p & ~sda_p & sda_s;
  // byte receive decode
  wire byte_done = (state_q == S_RX) && scl_rise && (cnt_q == 4'h7);
  wire [7:0] byte_w = {sh_q[6:0], sda_s};
  wire addr_ok = (byte_w[7:1] == {ADDR_HI, pins_s});
  wire hs_hit = (kind_q == K_ADDR) && first_q
                && (byte_w[7:3] == HS_CODE);
  wire sclr_full = (cmd_q == CMD_WR_SCLR)
                   && dhi_q[SCLR_FULL_BIT-8];
  wire ack_w = (kind_q == K_ADDR) ? (addr_ok & ~hs_hit)
             : (kind_q == K_DLO) ? ~sclr_full : 1'b1;
  wire wr_done = byte_done && (kind_q == K_DLO)
                 && !cmd_is_read(cmd_q);
  wire [15:0] wdata_w = {dhi_q, byte_w};
  // handshake slots
  wire rxack_end = (state_q == S_RXACK) && scl_fall;
  wire txack_end = (state_q == S_TXACK) && scl_fall;
  wire fetch = (rxack_end && ack_q && kind_q == K_ADDR && rd_q)
             || (txack_end && mack_q && tx_lo_q);
  wire next_lo = txack_end && mack_q && !tx_lo_q;
  // status word, rebuilt every cycle
  wire [15:0] status_w = {4'h0, i_converter_active, arith_q,
                          ~i_q_valid, ovf_q, alarm_q};
  // outgoing word for the register last named by a command
  wire is_q_rd = (last_q == CMD_RD_QUEUE);
  wire is_flag_rd = (last_q == CMD_RD_FLAG);
  wire [15:0] qword_w = !i_q_valid ? {TAG_EMPTY, status_w[11:0]}
                      : i_q_overflow ? {TAG_CORRUPT, i_q_word.value}
                      : {src_tag(i_q_word.src), i_q_word.value};
  wire [15:0] word_w = is_q_rd ? qword_w
                     : is_flag_rd ? status_w
                     : (last_q == CMD_RD_FINE1) ? {6'h00, fine1_q}
                     : (last_q == CMD_RD_FINE2) ? {6'h00, fine2_q}
                     : 16'h0000;
  wire flag_clr = fetch && is_flag_rd;
  // protocol state, kind of byte and bit counter
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q <= S_IDLE;
      kind_q <= K_ADDR;
      cnt_q <= 4'h0;
    end else if (stop_c) begin
      state_q <= S_IDLE;
    end else if (start_c) begin
      state_q <= S_RX;
      kind_q <= K_ADDR;
      cnt_q <= 4'h0;
    end else begin
      case (state_q)
        S_RX: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            state_q <= S_RXACK;
          end
        end
        S_RXACK: begin
          if (scl_fall) begin
            cnt_q <= 4'h0;
            if (!ack_q) begin
              state_q <= S_SKIP;
            end else if (kind_q == K_ADDR && rd_q) begin
              state_q <= S_TX;
            end else begin
              state_q <= S_RX;
              case (kind_q)
                K_ADDR: kind_q <= K_CMD;
                K_CMD: kind_q <= K_DHI;
                K_DHI: kind_q <= K_DLO;
                default: kind_q <= K_CMD;
              endcase
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            cnt_q <= (cnt_q == 4'h7) ? 4'h0 : cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
              state_q <= S_TXACK;
            end
          end
        end
        S_TXACK: begin
          if (scl_fall) begin
            state_q <= mack_q ? S_TX : S_SKIP;
          end
        end
        default: state_q <= state_q;
      endcase
    end
  end
  // shift register: receive on rising scl, send on falling scl
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sh_q <= 8'hFF;
    end else if (fetch) begin
      sh_q <= word_w[15:8];
    end else if (next_lo) begin
      sh_q <= txw_q[7:0];
    end else if (state_q == S_RX && scl_rise) begin
      sh_q <= byte_w;
    end else if (state_q == S_TX && scl_fall && cnt_q != 4'h7) begin
      sh_q <= {sh_q[6:0], 1'b1};
    end
  end
  // per-byte bookkeeping
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ack_q <= 1'b0;
      rd_q <= 1'b0;
      cmd_q <= 8'h00;
      last_q <= 8'h00;
      dhi_q <= 8'h00;
    end else if (byte_done) begin
      ack_q <= ack_w;
      if (kind_q == K_ADDR) begin
        rd_q <= byte_w[0];
      end
      if (kind_q == K_CMD) begin
        cmd_q <= byte_w;
        last_q <= byte_w;
      end
      if (kind_q == K_DHI) begin
        dhi_q <= byte_w;
      end
    end
  end
  // transmit word, byte half and the master's answer
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      txw_q <= 16'h0000;
      tx_lo_q <= 1'b0;
      mack_q <= 1'b0;
    end else begin
      if (fetch) begin
        txw_q <= word_w;
        tx_lo_q <= 1'b0;
      end else if (next_lo) begin
        tx_lo_q <= 1'b1;
      end
      if (state_q == S_TXACK && scl_rise) begin
        mack_q <= ~sda_s;
      end
    end
  end
  // bus activity and speed mode; a repeated start leaves both alone
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      bus_q <= 1'b0;
      first_q <= 1'b0;
      hs_q <= 1'b0;
      hs_pend_q <= 1'b0;
    end else if (stop_c) begin
      bus_q <= 1'b0;
      hs_q <= 1'b0;
      hs_pend_q <= 1'b0;
    end else if (start_c) begin
      bus_q <= 1'b1;
      first_q <= ~bus_q;
      hs_pend_q <= 1'b0;
    end else begin
      if (byte_done) begin
        first_q <= 1'b0;
        hs_pend_q <= hs_hit;
      end
      // the nack pulse is the ninth; its following rise is the tenth
      if (state_q == S_SKIP && scl_rise && hs_pend_q) begin
        hs_q <= 1'b1;
        hs_pend_q <= 1'b0;
      end
    end
  end
  // sticky overflow and alarms, arith follows its input; a new event beats a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ovf_q <= 1'b0;
      alarm_q <= ALARM_RST;
      arith_q <= ARITH_RST;
    end else begin
      ovf_q <= i_q_overflow | (ovf_q & ~flag_clr & ~clq_q);
      alarm_q <= i_alarm_set | (alarm_q & {8{~flag_clr}});
      arith_q <= i_arith_unit_active;
    end
  end
  // register writes: fine readbacks, software clear, write strobe
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      fine1_q <= FINE_RST;
      fine2_q <= FINE_RST;
      armed_q <= 1'b0;
      clq_q <= 1'b0;
      full_q <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_q <= '0;
    end else begin
      clq_q <= wr_done && cmd_q == CMD_WR_SCLR && byte_w[SCLR_CLQ_BIT];
      full_q <= wr_done && sclr_full && armed_q;
      wr_stb_q <= wr_done;
      if (wr_done) begin
        wr_q <= '{cmd: cmd_q, data: wdata_w};
        if (cmd_q == CMD_WR_FINE1) begin
          fine1_q <= wdata_w[FINE_W-1:0];
        end
        if (cmd_q == CMD_WR_FINE2) begin
          fine2_q <= wdata_w[FINE_W-1:0];
        end
        if (cmd_q == CMD_WR_SCLR) begin
          armed_q <= wdata_w[SCLR_ARM_BIT] & ~wdata_w[SCLR_FULL_BIT];
        end
      end
    end
  end
  // open drain: drive low only for an ack or a zero data bit
  wire drive_lo = (state_q == S_RXACK && ack_q)
                || (state_q == S_TX && !sh_q[7]);
  assign o_sda_o = 1'b0;
  assign o_sda_oe_n = ~drive_lo;
  assign o_q_pop = fetch && is_q_rd && i_q_valid;
  assign o_q_clear = clq_q;
  assign o_complete_dac_clear = full_q;
  assign o_wr_stb = wr_stb_q;
  assign o_wr = wr_q;
  assign o_hs_mode = hs_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  corrupt_tag_a: assert property (
    fetch && is_q_rd && i_q_valid && i_q_overflow
    |=> txw_q[15:12] == TAG_CORRUPT)
    else $error("overflow during readout not tagged corrupt");
  empty_tag_a: assert property (
    fetch && is_q_rd && !i_q_valid
    |=> txw_q == {TAG_EMPTY, $past(status_w[11:0])})
    else $error("empty queue word wrong");
  queue_word_a: assert property (
    fetch && is_q_rd && i_q_valid && !i_q_overflow
    && i_q_word.src <= SRC_LAST
    |=> txw_q == {1'b0, $past(i_q_word.src), $past(i_q_word.value)})
    else $error("queue word layout wrong");
  tag_range_a: assert property (
    fetch && is_q_rd |=> txw_q[15:12] <= 4'h6 || txw_q[15:12] >= 4'hE)
    else $error("reserved tag sent");
  flag_clear_a: assert property (
    flag_clr && !i_q_overflow && i_alarm_set == 8'h00
    |=> !ovf_q && alarm_q == 8'h00)
    else $error("status read did not clear flags");
  ovf_wins_a: assert property (
    i_q_overflow |=> ovf_q)
    else $error("overflow event lost");
  addr_match_a: assert property (
    state_q == S_RXACK && kind_q == K_ADDR && ack_q
    |-> sh_q[7:1] == {ADDR_HI, pins_s})
    else $error("acked foreign address");
  ack_drive_a: assert property (
    state_q == S_RXACK && ack_q |-> !o_sda_oe_n)
    else $error("ack not driven");
  msb_first_a: assert property (
    state_q == S_TX |-> o_sda_oe_n == txw_q[{~tx_lo_q, ~cnt_q[2:0]}])
    else $error("data bit not on line");
  full_nack_a: assert property (
    byte_done && kind_q == K_DLO && sclr_full |=> !ack_q)
    else $error("acked full clear write");
  stop_fast_a: assert property (
    stop_c |=> state_q == S_IDLE && !hs_q)
    else $error("stop did not return to fast idle");
  start_seen_c: cover property (start_c ##[1:1000] byte_done);
  queue_read_c: cover property (fetch && is_q_rd && i_q_valid);
  hs_entry_c: cover property ($rose(hs_q));
  write_c: cover property (wr_done);
endmodule // bci_slave

/* bci_mst.sv */
// two-wire bus master model facing the slave's bus pins
`timescale 1ns/10ps
module bci_mst (
  output logic o_scl,
  output logic o_sda_pull,
  input wire logic i_sda
);
  // both lines rest high between frames, clock stands still
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end

  // one bit: data moves in the long low phase, sampled at the rise
  // low phase is long since the slave answers some clocks late
  task automatic bit_io(input logic b, output logic s);
    #80 o_sda_pull = ~b;
    #160 o_scl = 1'b1;
    s = i_sda;
    #80 o_scl = 1'b0;
  endtask

  // start or repeated start, data falls while clock is high
  task automatic start();
    if (o_scl === 1'b0) begin
      #80 o_sda_pull = 1'b0;
      #160 o_scl = 1'b1;
    end
    #160 o_sda_pull = 1'b1;
    #160 o_scl = 1'b0;
  endtask

  // stop, data rises while clock is high
  task automatic stop();
    #80 o_sda_pull = 1'b1;
    #160 o_scl = 1'b1;
    #160 o_sda_pull = 1'b0;
    #320;
  endtask

  // byte out msb first, then the ninth bit is the slave's answer
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask

  // byte in msb first, then our ack (0) or nack (1)
  task automatic get(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(ack, s);
  endtask
endmodule // bci_mst

/* i2c_slave_register_access_tb.sv */
// self-checking bench for the two-wire slave register access
`timescale 1ns/10ps
module i2c_slave_register_access_tb
  import bci_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] pins = 3'h0;
  logic q_valid = 1'b0;
  bci_qin_s q_word = '0;
  logic ovf_at_pop = 1'b0;
  logic ovf_pulse = 1'b0;
  logic conv = 1'b0;
  logic arith = 1'b0;
  logic [7:0] alarm = 8'h00;
  logic scl, pull, sda_o, sda_oe_n, q_pop, q_clear, full_clr, wr_stb, hs;
  bci_wr_s wr;
  bci_wr_s last_wr;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n_pop = 0;
  int n_qclr = 0;
  int n_full = 0;
  int n_wr = 0;
  // open-drain data line with pull-up
  wire sda = (pull | (sda_oe_n === 1'b0 && sda_o === 1'b0)) ? 1'b0 : 1'b1;
  wire q_ovf = ovf_pulse | (ovf_at_pop & q_pop);

  always #20 clk = ~clk;

  bci_slave i_dut (
    .i_clk(clk), .i_srst(srst), .i_scl(scl), .i_sda(sda),
    .i_addr_pin_bit0(pins[0]), .i_addr_pin_bit1(pins[1]),
    .i_addr_pin_bit2(pins[2]), .i_q_valid(q_valid), .i_q_word(q_word),
    .i_q_overflow(q_ovf), .i_converter_active(conv),
    .i_arith_unit_active(arith), .i_alarm_set(alarm),
    .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n), .o_q_pop(q_pop),
    .o_q_clear(q_clear), .o_complete_dac_clear(full_clr),
    .o_wr_stb(wr_stb), .o_wr(wr), .o_hs_mode(hs)
  );

  bci_mst i_mst (.o_scl(scl), .o_sda_pull(pull), .i_sda(sda));

  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // count strobes and cut a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (q_pop === 1'b1) n_pop <= n_pop + 1;
    if (q_clear === 1'b1) n_qclr <= n_qclr + 1;
    if (full_clr === 1'b1) n_full <= n_full + 1;
    if (wr_stb === 1'b1) begin
      n_wr <= n_wr + 1;
      last_wr <= wr;
    end
    if (cycles == 60000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [15:0] st_exp(input logic ovf,
                                         input logic [7:0] al);
    return {4'h0, conv, arith, ~q_valid, ovf, al};
  endfunction

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic put_chk(input logic [7:0] b, input logic exp);
    logic a;
    i_mst.put(b, a);
    check("ack", 16'(exp), 16'(a));
  endtask

  task automatic addr(input logic rw);
    put_chk({ADDR_HI, pins, rw}, 1'b0);
  endtask

  task automatic rd16(input logic nack, output logic [15:0] w);
    i_mst.get(1'b0, w[15:8]);
    i_mst.get(nack, w[7:0]);
  endtask

  task automatic cmd_read(input logic [7:0] c, output logic [15:0] w);
    i_mst.start();
    addr(1'b0);
    put_chk(c, 1'b0);
    i_mst.start();
    addr(1'b1);
    rd16(1'b1, w);
    i_mst.stop();
  endtask

  task automatic short_read(output logic [15:0] w);
    i_mst.start();
    addr(1'b1);
    rd16(1'b1, w);
    i_mst.stop();
  endtask

  task automatic write(input logic [7:0] c, input logic [15:0] d,
                       input logic lo_ack);
    i_mst.start();
    addr(1'b0);
    put_chk(c, 1'b0);
    put_chk(d[15:8], 1'b0);
    put_chk(d[7:0], lo_ack);
    i_mst.stop();
  endtask

  // main sequence: random straps, data and flags, fixed corner cases
  initial begin
    logic [15:0] w;
    logic [15:0] d;
    logic [7:0] al;
    logic [7:0] c;
    int k;
    void'($urandom(77));
    pins = 3'($urandom);
    conv = 1'($urandom);
    arith = 1'($urandom);
    repeat (6) @(posedge clk);
    #1;
    srst = 1'b0;
    repeat (6) tick();
    check("hs", 16'h0000, 16'(hs));
    cmd_read(CMD_RD_FLAG, w);
    check("status", st_exp(1'b0, 8'h00), w);
    // sticky flags seen once, then cleared on the repeat word
    al = 8'($urandom);
    tick();
    alarm = al;
    ovf_pulse = 1'b1;
    tick();
    alarm = 8'h00;
    ovf_pulse = 1'b0;
    cmd_read(CMD_RD_FLAG, w);
    check("flags", st_exp(1'b1, al), w);
    i_mst.start();
    addr(1'b1);
    rd16(1'b0, w);
    rd16(1'b1, d);
    i_mst.stop();
    check("cleared", st_exp(1'b0, 8'h00), w);
    check("again", st_exp(1'b0, 8'h00), d);
    // every source code once, one pop per word
    q_valid = 1'b1;
    for (int s = 0; s <= 6; s++) begin
      q_word = '{src: 3'(s), value: (s == 6) ? 12'hFFF : 12'($urandom)};
      k = n_pop;
      if (s == 0) cmd_read(CMD_RD_QUEUE, w);
      else short_read(w);
      check("queue", {1'b0, q_word.src, q_word.value}, w);
      check("pops", 16'(k + 1), 16'(n_pop));
    end
    tick();
    ovf_at_pop = 1'b1;
    short_read(w);
    check("corrupt", {TAG_CORRUPT, q_word.value}, w);
    tick();
    ovf_at_pop = 1'b0;
    q_valid = 1'b0;
    k = n_pop;
    short_read(w);
    d = st_exp(1'b1, 8'h00);
    check("empty", {TAG_EMPTY, d[11:0]}, w);
    check("no pop", 16'(k), 16'(n_pop));
    // write then readback chained in one transaction
    for (int i = 0; i < 2; i++) begin
      c = i ? CMD_WR_FINE2 : CMD_WR_FINE1;
      d = 16'($urandom);
      k = n_wr;
      i_mst.start();
      addr(1'b0);
      put_chk(c, 1'b0);
      put_chk(d[15:8], 1'b0);
      put_chk(d[7:0], 1'b0);
      put_chk(i ? CMD_RD_FINE2 : CMD_RD_FINE1, 1'b0);
      i_mst.start();
      addr(1'b1);
      rd16(1'b1, w);
      i_mst.stop();
      check("wr cmd", 16'(c), 16'(last_wr.cmd));
      check("wr data", d, last_wr.data);
      check("wr count", 16'(k + 1), 16'(n_wr));
      check("readback", {6'h00, d[9:0]}, {6'h00, w[9:0]});
    end
    // foreign address refused, rest of transfer ignored
    k = n_wr;
    i_mst.start();
    put_chk({ADDR_HI, pins ^ 3'($urandom_range(7, 1)), 1'b0}, 1'b1);
    put_chk(CMD_WR_FINE1, 1'b1);
    i_mst.start();
    put_chk({4'h5, pins, 1'b0}, 1'b1);
    put_chk(CMD_WR_FINE1, 1'b1);
    i_mst.stop();
    check("ignored", 16'(k), 16'(n_wr));
    // armed full clear, queue clear, both via the clear register
    k = n_full;
    write(CMD_WR_SCLR, 16'h0100, 1'b0);
    write(CMD_WR_SCLR, 16'h0200, 1'b1);
    check("full clr", 16'(k + 1), 16'(n_full));
    // full clear without a fresh arm is still refused but does nothing
    write(CMD_WR_SCLR, 16'h0200, 1'b1);
    check("unarmed", 16'(k + 1), 16'(n_full));
    k = n_qclr;
    write(CMD_WR_SCLR, 16'h0040, 1'b0);
    check("q clr", 16'(k + 1), 16'(n_qclr));
    cmd_read(CMD_RD_FLAG, w);
    check("ovf gone", st_exp(1'b0, 8'h00), w);
    // high-speed code: refused, kept over Sr, ended by stop
    i_mst.start();
    put_chk({HS_CODE, 3'($urandom)}, 1'b1);
    i_mst.start();
    check("hs on", 16'h0001, 16'(hs));
    addr(1'b1);
    rd16(1'b1, w);
    i_mst.stop();
    check("hs read", st_exp(1'b0, 8'h00), w);
    check("hs off", 16'h0000, 16'(hs));
    check("idle", 16'h0001, 16'(sda_oe_n));
    give_verdict();
  end
endmodule // i2c_slave_register_access_tb
